// File: rtl/apr_pkg.sv
// constants and types shared by the parallel conversion request sources
// Operation
// - run bit loads counter, arbiter tick clocks it
// - each tick decrements; at/below boundary locks
// - underflow reloads, relocks only if reload at/below boundary, flags service, triggers
// - period is reload plus one times twenty
// - underflow ORs timer select into timer pending
// - timer participates on lock or pending bits
// - timer win clears started channel bit; empty and unlocked clears flag
// - cancelled timer conversion sets its bit again
// - clearing participation flag clears whole pending mask
// - lock blocks sources ranked below the timer
// - zero boundary never locks arbitration
// - reload at/below boundary keeps lock permanently
// - lock status clears on run clear, or on underflow with reload above boundary
// - select bit picks port or peripheral trigger
// - edge mode none, rising, falling or both
// - detected event ORs select mask into pending
// - external flag, win clear, cancel restore, empty
// - trigger onto already pending bit is lost
// - request write copies into software pending mask
// - software flag, win clear, cancel restore, empty
// - zero written clears matching software pending bit
// - all masks sixteen bits, bit n channel n
package apr_pkg;

  localparam int CH_W     = 16; // channels per mask
  localparam int CHIDX_W  = 4;  // channel number width
  localparam int CNT_W    = 10; // timer counter, reload and boundary width
  localparam int ADDR_W   = 8;  // apb address width
  localparam int DATA_W   = 32; // apb data width
  localparam int DIV_W    = 5;  // converter clock divider width
  localparam int NPATH    = 2;  // external trigger paths

  // converter clocks per timer tick
  localparam logic [DIV_W-1:0] TICK_DIV = 5'h14;

  // register byte addresses
  localparam logic [ADDR_W-1:0] A_TCTRL = 8'h00; // run, reload, boundary
  localparam logic [ADDR_W-1:0] A_TSTAT = 8'h04; // lock, service, count
  localparam logic [ADDR_W-1:0] A_TSEL  = 8'h08; // timer select mask
  localparam logic [ADDR_W-1:0] A_TPEND = 8'h0C; // timer pending mask
  localparam logic [ADDR_W-1:0] A_ECTRL = 8'h10; // source select, edges
  localparam logic [ADDR_W-1:0] A_ESEL0 = 8'h14; // path 0 select mask
  localparam logic [ADDR_W-1:0] A_ESEL1 = 8'h18; // path 1 select mask
  localparam logic [ADDR_W-1:0] A_EPEND = 8'h1C; // external pending mask
  localparam logic [ADDR_W-1:0] A_SWREQ = 8'h20; // software request
  localparam logic [ADDR_W-1:0] A_SPEND = 8'h24; // software pending mask
  localparam logic [ADDR_W-1:0] A_PART  = 8'h28; // participation flags

  // field positions
  localparam int TC_RLD_LSB = 0;  // reload value
  localparam int TC_BND_LSB = 16; // lock boundary
  localparam int TC_RUN     = 31; // run bit
  localparam int TS_LOCK    = 0;  // lock status
  localparam int TS_SVC     = 1;  // service flag, write one clears
  localparam int TS_CNT_LSB = 16; // current count
  localparam int EC_STRIDE  = 4;  // bits per path in A_ECTRL
  localparam int EC_SEL     = 0;  // 1 = peripheral input
  localparam int EC_EDGE    = 1;  // two-bit edge mode
  localparam int PT_TMR     = 0;  // timer participation
  localparam int PT_EXT     = 1;  // external participation
  localparam int PT_SW      = 2;  // software participation

  // reset values
  localparam logic [CH_W-1:0]  MASK_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST  = 10'h000;

  // request source codes used by the arbiter
  typedef enum logic [1:0] {
    SRC_TIMER = 2'h0,
    SRC_EXT   = 2'h1,
    SRC_SW    = 2'h2
  } apr_src_e;

  // edge detector modes
  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } apr_edge_e;

endpackage : apr_pkg

// File: rtl/apr_request_sources.sv
// timer, external event and software conversion request sources
`timescale 1ns/1ps
module apr_request_sources (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [apr_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [apr_pkg::DATA_W-1:0]  pwdata,
  output logic                             pready,
  output logic [apr_pkg::DATA_W-1:0]       prdata,
  output logic                             pslverr,
  // converter clock enable from the arbiter
  input  wire logic                        conv_clk_en,
  // arbiter start and cancel reports
  input  wire logic                        start_valid,
  input  wire logic [1:0]                  start_src,
  input  wire logic [apr_pkg::CHIDX_W-1:0] start_chan,
  input  wire logic                        cancel_valid,
  input  wire logic [1:0]                  cancel_src,
  input  wire logic [apr_pkg::CHIDX_W-1:0] cancel_chan,
  // sources ranked below the timer: bit0 external, bit1 software
  input  wire logic [1:0]                  below_timer,
  // trigger inputs
  input  wire logic [apr_pkg::NPATH-1:0]   port_trigger_input,
  input  wire logic [apr_pkg::NPATH-1:0]   peripheral_trigger_input,
  // state seen by the arbiter
  output logic                             arb_lock_status,
  output logic                             timer_trigger,
  output logic [apr_pkg::CH_W-1:0]         timer_pending_mask,
  output logic [apr_pkg::CH_W-1:0]         ext_pending_mask,
  output logic [apr_pkg::CH_W-1:0]         sw_pending_mask,
  output logic                             timer_participation_flag,
  output logic                             ext_participation_flag,
  output logic                             sw_participation_flag
);

  localparam int CH = apr_pkg::CH_W;
  localparam int CW = apr_pkg::CNT_W;

  // one-hot mask of a channel number
  function automatic logic [CH-1:0] chan_bit(
    input logic [apr_pkg::CHIDX_W-1:0] ch
  );
    return {{(CH-1){1'b0}}, 1'b1} << ch;
  endfunction : chan_bit

  // edge detection for one path by mode
  function automatic logic edge_hit(
    input logic [1:0] mode,
    input logic       now,
    input logic       prev
  );
    logic hit;
    case (mode)
      apr_pkg::EDGE_RISE: hit = now & ~prev;
      apr_pkg::EDGE_FALL: hit = ~now & prev;
      apr_pkg::EDGE_BOTH: hit = now ^ prev;
      default:            hit = 1'b0; // none suppresses the path
    endcase
    return hit;
  endfunction : edge_hit

  // software registers
  logic          timer_run_bit;          // timer enable
  logic [CW-1:0] timer_reload_value;     // counter reload
  logic [CW-1:0] lock_boundary;          // lock compare value
  logic          timer_service_flag;     // sticky underflow flag
  logic [CH-1:0] timer_trigger_select_mask;
  logic [CH-1:0] ext_sel0;               // path 0 channel select
  logic [CH-1:0] ext_sel1;               // path 1 channel select
  logic [apr_pkg::NPATH-1:0] trigger_source_select; // 1 = peripheral
  logic [1:0]    edge_mode0;             // path 0 edge mode
  logic [1:0]    edge_mode1;             // path 1 edge mode
  logic [CH-1:0] sw_request_reg;         // software request

  // timer state
  logic [CW-1:0]          count;         // down-counter
  logic                   run_q;         // run bit one cycle ago
  logic [apr_pkg::DIV_W-1:0] div;        // converter clock divider
  logic [apr_pkg::NPATH-1:0] trig_q;     // previous selected trigger

  // bus decode
  logic                   acc;           // access phase, answer cycle
  logic                   wr;            // write takes effect
  logic                   hit;           // address is mapped
  logic [apr_pkg::DATA_W-1:0] rd_val;    // read mux

  // timer events
  logic run_rise;                        // run bit just set
  logic tick;                            // timer clock enable
  logic underflow;                       // counter passes zero
  logic [CW-1:0] count_dec;              // count minus one

  // per source clears and restores
  logic [CH-1:0] clr_t, clr_e, clr_s;    // conversion starts
  logic [CH-1:0] rst_t, rst_e, rst_s;    // cancellations
  logic          gclr_t, gclr_e, gclr_s; // participation flag cleared
  logic          blk_e, blk_s;           // start blocked by lock
  logic [apr_pkg::NPATH-1:0] trig_now;   // selected trigger levels
  logic [apr_pkg::NPATH-1:0] ev;         // detected events
  logic [CH-1:0] ev_set;                 // external bits to raise
  logic          sw_wr;                  // software request write

  logic [CH-1:0] next_tpend, next_epend, next_spend;
  logic          next_lock;

  // access phase decode
  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;
  assign sw_wr = wr & (paddr == apr_pkg::A_SWREQ);

  // lock active only with nonzero boundary, at or below it
  function automatic logic lock_at(input logic [CW-1:0] v);
    return (lock_boundary != '0) && (v <= lock_boundary);
  endfunction : lock_at

  // apb slave

  // address decode for mapped registers
  always_comb begin
    hit = 1'b1;
    rd_val = '0;
    case (paddr)
      apr_pkg::A_TCTRL: begin
        rd_val[apr_pkg::TC_RUN] = timer_run_bit;
        rd_val[apr_pkg::TC_RLD_LSB +: CW] = timer_reload_value;
        rd_val[apr_pkg::TC_BND_LSB +: CW] = lock_boundary;
      end
      apr_pkg::A_TSTAT: begin
        rd_val[apr_pkg::TS_LOCK] = arb_lock_status;
        rd_val[apr_pkg::TS_SVC] = timer_service_flag;
        rd_val[apr_pkg::TS_CNT_LSB +: CW] = count;
      end
      apr_pkg::A_TSEL:  rd_val[CH-1:0] = timer_trigger_select_mask;
      apr_pkg::A_TPEND: rd_val[CH-1:0] = timer_pending_mask;
      apr_pkg::A_ECTRL: begin
        rd_val[apr_pkg::EC_SEL] = trigger_source_select[0];
        rd_val[apr_pkg::EC_EDGE +: 2] = edge_mode0;
        rd_val[apr_pkg::EC_STRIDE + apr_pkg::EC_SEL] =
          trigger_source_select[1];
        rd_val[apr_pkg::EC_STRIDE + apr_pkg::EC_EDGE +: 2] = edge_mode1;
      end
      apr_pkg::A_ESEL0: rd_val[CH-1:0] = ext_sel0;
      apr_pkg::A_ESEL1: rd_val[CH-1:0] = ext_sel1;
      apr_pkg::A_EPEND: rd_val[CH-1:0] = ext_pending_mask;
      apr_pkg::A_SWREQ: rd_val[CH-1:0] = sw_request_reg;
      apr_pkg::A_SPEND: rd_val[CH-1:0] = sw_pending_mask;
      apr_pkg::A_PART: begin
        rd_val[apr_pkg::PT_TMR] = timer_participation_flag;
        rd_val[apr_pkg::PT_EXT] = ext_participation_flag;
        rd_val[apr_pkg::PT_SW]  = sw_participation_flag;
      end
      default: hit = 1'b0; // unmapped: error, zero data
    endcase
  end

  // one wait state, answer stands one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_val : '0;
      pslverr <= psel & penable & ~pready & ~hit;
    end
  end

  // plain control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_run_bit             <= 1'b0;
      timer_reload_value        <= apr_pkg::CNT_RST;
      lock_boundary             <= apr_pkg::CNT_RST;
      timer_trigger_select_mask <= apr_pkg::MASK_RST;
      ext_sel0                  <= apr_pkg::MASK_RST;
      ext_sel1                  <= apr_pkg::MASK_RST;
      trigger_source_select     <= '0;
      edge_mode0                <= apr_pkg::EDGE_NONE;
      edge_mode1                <= apr_pkg::EDGE_NONE;
      sw_request_reg            <= apr_pkg::MASK_RST;
    end else if (wr) begin
      case (paddr)
        apr_pkg::A_TCTRL: begin
          timer_run_bit      <= pwdata[apr_pkg::TC_RUN];
          timer_reload_value <= pwdata[apr_pkg::TC_RLD_LSB +: CW];
          lock_boundary      <= pwdata[apr_pkg::TC_BND_LSB +: CW];
        end
        apr_pkg::A_TSEL:  timer_trigger_select_mask <= pwdata[CH-1:0];
        apr_pkg::A_ECTRL: begin
          trigger_source_select[0] <= pwdata[apr_pkg::EC_SEL];
          edge_mode0 <= pwdata[apr_pkg::EC_EDGE +: 2];
          trigger_source_select[1] <=
            pwdata[apr_pkg::EC_STRIDE + apr_pkg::EC_SEL];
          edge_mode1 <= pwdata[apr_pkg::EC_STRIDE + apr_pkg::EC_EDGE +: 2];
        end
        apr_pkg::A_ESEL0: ext_sel0 <= pwdata[CH-1:0];
        apr_pkg::A_ESEL1: ext_sel1 <= pwdata[CH-1:0];
        // request keeps its written value
        apr_pkg::A_SWREQ: sw_request_reg <= pwdata[CH-1:0];
        default: ;
      endcase
    end
  end

  // timer

  assign run_rise  = timer_run_bit & ~run_q;
  assign tick      = timer_run_bit & conv_clk_en &
                     (div == apr_pkg::TICK_DIV - 1'b1);
  assign underflow = tick & ~run_rise & (count == '0);
  assign count_dec = count - 1'b1;

  // divider restarts with the run bit so ticks follow arbitration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div   <= '0;
      run_q <= 1'b0;
    end else begin
      run_q <= timer_run_bit;
      if (!timer_run_bit || run_rise) begin
        div <= '0;
      end else if (conv_clk_en) begin
        div <= (div == apr_pkg::TICK_DIV - 1'b1) ? '0 : div + 1'b1;
      end
    end
  end

  // lock next value from counter progress
  always_comb begin
    next_lock = arb_lock_status;
    if (!timer_run_bit) begin
      next_lock = 1'b0;
    end else if (run_rise) begin
      next_lock = lock_at(timer_reload_value);
    end else if (underflow) begin
      // relock at once if reload at or below boundary
      next_lock = lock_at(timer_reload_value);
    end else if (tick && lock_at(count_dec)) begin
      next_lock = 1'b1;
    end
  end

  // counter load, decrement and reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= apr_pkg::CNT_RST;
    end else if (run_rise) begin
      count <= timer_reload_value;
    end else if (underflow) begin
      count <= timer_reload_value;
    end else if (tick) begin
      count <= count_dec;
    end
  end

  // lock status, trigger pulse and sticky service flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_lock_status    <= 1'b0;
      timer_trigger      <= 1'b0;
      timer_service_flag <= 1'b0;
    end else begin
      arb_lock_status <= next_lock;
      timer_trigger   <= underflow;
      // set wins over a write-one clear
      if (underflow) begin
        timer_service_flag <= 1'b1;
      end else if (wr && paddr == apr_pkg::A_TSTAT &&
                   pwdata[apr_pkg::TS_SVC]) begin
        timer_service_flag <= 1'b0;
      end
    end
  end

  // arbiter start and cancel

  // lower ranked sources may not start while locked
  assign blk_e = arb_lock_status & below_timer[0];
  assign blk_s = arb_lock_status & below_timer[1];

  // decode start and cancel into per source bit masks
  always_comb begin
    clr_t = '0;
    clr_e = '0;
    clr_s = '0;
    rst_t = '0;
    rst_e = '0;
    rst_s = '0;
    if (start_valid) begin
      case (start_src)
        apr_pkg::SRC_TIMER: clr_t = chan_bit(start_chan);
        apr_pkg::SRC_EXT:   clr_e = blk_e ? '0 : chan_bit(start_chan);
        apr_pkg::SRC_SW:    clr_s = blk_s ? '0 : chan_bit(start_chan);
        default: ;
      endcase
    end
    if (cancel_valid) begin
      case (cancel_src)
        apr_pkg::SRC_TIMER: rst_t = chan_bit(cancel_chan);
        apr_pkg::SRC_EXT:   rst_e = chan_bit(cancel_chan);
        apr_pkg::SRC_SW:    rst_s = chan_bit(cancel_chan);
        default: ;
      endcase
    end
  end

  // participation flag written to zero clears the whole mask
  assign gclr_t = wr & (paddr == apr_pkg::A_PART) &
                  ~pwdata[apr_pkg::PT_TMR];
  assign gclr_e = wr & (paddr == apr_pkg::A_PART) &
                  ~pwdata[apr_pkg::PT_EXT];
  assign gclr_s = wr & (paddr == apr_pkg::A_PART) &
                  ~pwdata[apr_pkg::PT_SW];

  // external triggers

  // choose port or peripheral input per path
  assign trig_now = (trigger_source_select & peripheral_trigger_input) |
                    (~trigger_source_select & port_trigger_input);
  assign ev[0] = edge_hit(edge_mode0, trig_now[0], trig_q[0]);
  assign ev[1] = edge_hit(edge_mode1, trig_now[1], trig_q[1]);
  // events from both paths merge into one mask
  assign ev_set = ({CH{ev[0]}} & ext_sel0) | ({CH{ev[1]}} & ext_sel1);

  // previous trigger level, one clock wide pulses are seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= '0;
    end else begin
      trig_q <= trig_now;
    end
  end

  // pending masks

  // clears first, then sets, so new requests win
  always_comb begin
    next_tpend = timer_pending_mask & ~clr_t & ~{CH{gclr_t}};
    next_tpend = next_tpend | rst_t;
    if (underflow) begin
      next_tpend = next_tpend | timer_trigger_select_mask;
    end
    // already pending bits simply stay set, extra event is lost
    next_epend = ext_pending_mask & ~clr_e & ~{CH{gclr_e}};
    next_epend = next_epend | rst_e | ev_set;
    // request write replaces the mask, zeros cancel bits
    if (sw_wr) begin
      next_spend = pwdata[CH-1:0] | rst_s;
    end else begin
      next_spend = (sw_pending_mask & ~clr_s & ~{CH{gclr_s}}) | rst_s;
    end
  end

  // masks and flags follow their next values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_pending_mask       <= apr_pkg::MASK_RST;
      ext_pending_mask         <= apr_pkg::MASK_RST;
      sw_pending_mask          <= apr_pkg::MASK_RST;
      timer_participation_flag <= 1'b0;
      ext_participation_flag   <= 1'b0;
      sw_participation_flag    <= 1'b0;
    end else begin
      timer_pending_mask <= next_tpend;
      ext_pending_mask   <= next_epend;
      sw_pending_mask    <= next_spend;
      timer_participation_flag <= next_lock | (|next_tpend);
      ext_participation_flag   <= |next_epend;
      sw_participation_flag    <= |next_spend;
    end
  end

endmodule : apr_request_sources

// File: tb/apr_partner.sv
// arbiter and trigger peripheral model facing the request sources
`timescale 1ns/1ps
module apr_partner (
  input  wire logic                   pclk,
  output logic                        conv_clk_en,
  output logic                        start_valid,
  output logic [1:0]                  start_src,
  output logic [apr_pkg::CHIDX_W-1:0] start_chan,
  output logic                        cancel_valid,
  output logic [1:0]                  cancel_src,
  output logic [apr_pkg::CHIDX_W-1:0] cancel_chan,
  output logic [apr_pkg::NPATH-1:0]   port_trigger_input,
  output logic [apr_pkg::NPATH-1:0]   peripheral_trigger_input
);
  // enable every cycle: a tick is 20 cycles
  initial begin
    {conv_clk_en, start_valid, cancel_valid} = 3'b100;
    {start_src, start_chan, cancel_src, cancel_chan} = 12'hFFF;
    {port_trigger_input, peripheral_trigger_input} = 4'h0;
  end
  // one report cycle, then released fields inverted
  task automatic arb(input logic sv, input logic [1:0] ss,
    input logic [3:0] sc, input logic cv, input logic [1:0] cs,
    input logic [3:0] cc);
    @(posedge pclk);
    start_valid <= sv;
    start_src <= ss;
    start_chan <= sc;
    cancel_valid <= cv;
    cancel_src <= cs;
    cancel_chan <= cc;
    @(posedge pclk);
    start_valid <= 1'b0;
    start_src <= ~ss;
    start_chan <= ~sc;
    cancel_valid <= 1'b0;
    cancel_src <= ~cs;
    cancel_chan <= ~cc;
  endtask : arb
  // rise, then fall, each held three cycles
  task automatic pulse(input bit per, input int path);
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      if (per) peripheral_trigger_input[path] <= (i == 0);
      else port_trigger_input[path] <= (i == 0);
      repeat (2) @(posedge pclk);
    end
  endtask : pulse
endmodule : apr_partner

// File: tb/apr_request_sources_bench.sv
// directed bench for the parallel conversion request sources
`timescale 1ns/1ps
module apr_request_sources_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        conv_clk_en, start_valid, cancel_valid, arb_lock_status;
  logic [1:0]  start_src, cancel_src, below_timer, port_t, per_t;
  logic [3:0]  start_chan, cancel_chan;
  logic        timer_trigger, t_flag, e_flag, s_flag;
  logic [15:0] t_pend, e_pend, s_pend;
  int          num_errors, n_compared, cyc, n, lk;
  apr_request_sources dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .conv_clk_en,
    .start_valid, .start_src, .start_chan, .cancel_valid, .cancel_src,
    .cancel_chan, .below_timer, .port_trigger_input(port_t),
    .peripheral_trigger_input(per_t), .arb_lock_status, .timer_trigger,
    .timer_pending_mask(t_pend), .ext_pending_mask(e_pend),
    .sw_pending_mask(s_pend), .timer_participation_flag(t_flag),
    .ext_participation_flag(e_flag), .sw_participation_flag(s_flag));
  apr_partner u_far (.pclk, .conv_clk_en, .start_valid, .start_src,
    .start_chan, .cancel_valid, .cancel_src, .cancel_chan,
    .port_trigger_input(port_t), .peripheral_trigger_input(per_t));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("BAD %0t got %h want %h", $time, g, e);
      num_errors++;
    end
  endtask : chk
  // apb master, holds until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : apb
  // one timer period, lock cycles counted
  task automatic period();
    n = 0;
    lk = 0;
    do @(posedge pclk); while (timer_trigger !== 1'b1);
    do begin
      @(posedge pclk);
      n++;
      if (arb_lock_status === 1'b1) lk++;
    end while (timer_trigger !== 1'b1);
  endtask : period
  initial begin
    {presetn, psel, penable, pwrite, cyc, num_errors, n_compared} = '0;
    {paddr, pwdata} = '0;
    below_timer = 2'h3;
    repeat (16) @(posedge pclk);
    chk(32'({t_pend, e_pend, s_pend, timer_trigger, arb_lock_status}), 0);
    presetn <= 1'b1;
    apb(1, apr_pkg::A_TSEL, 32'h0000_8001);
    apb(1, apr_pkg::A_TCTRL, 32'h8001_0002);
    period();
    chk(32'(n), 32'h0000_003C);
    chk(32'(lk), 32'h0000_0028);
    @(negedge pclk);
    chk(32'({t_flag, t_pend}), 32'h0001_8001);
    apb(0, apr_pkg::A_TSTAT, 0);
    chk(rdat & 32'h0000_0003, 32'h0000_0002);
    u_far.arb(1, apr_pkg::SRC_TIMER, 15, 0, 0, 0);
    @(negedge pclk);
    chk(32'(t_pend), 32'h0000_0001);
    u_far.arb(1, apr_pkg::SRC_TIMER, 0, 1, apr_pkg::SRC_TIMER, 15);
    @(negedge pclk);
    chk(32'(t_pend), 32'h0000_8000);
    u_far.arb(1, apr_pkg::SRC_TIMER, 15, 1, apr_pkg::SRC_TIMER, 15);
    @(negedge pclk);
    chk(32'(t_pend), 32'h0000_8000);
    apb(1, apr_pkg::A_TCTRL, 32'h0001_0002);
    apb(1, apr_pkg::A_PART, 32'h0000_0006);
    @(negedge pclk);
    chk(32'({arb_lock_status, t_flag, t_pend}), 0);
    apb(1, apr_pkg::A_TCTRL, 32'h8000_0002);
    period();
    chk(32'(lk), 0);
    apb(1, apr_pkg::A_TCTRL, 32'h0000_0002);
    apb(1, apr_pkg::A_TCTRL, 32'h8003_0001);
    period();
    chk({n[15:0], lk[15:0]}, 32'h0028_0028);
    apb(1, apr_pkg::A_SWREQ, 32'h0000_0020);
    u_far.arb(1, apr_pkg::SRC_SW, 5, 0, 0, 0);
    @(negedge pclk);
    chk(32'(s_pend), 32'h0000_0020);
    apb(1, apr_pkg::A_TCTRL, 32'h0003_0001);
    u_far.arb(1, apr_pkg::SRC_SW, 5, 0, 0, 0);
    @(negedge pclk);
    chk(32'({arb_lock_status, s_flag, s_pend}), 0);
    apb(1, apr_pkg::A_SWREQ, 32'h0000_00A5);
    apb(0, apr_pkg::A_SWREQ, 0);
    chk(rdat, 32'h0000_00A5);
    apb(1, apr_pkg::A_SWREQ, 32'h0000_0021);
    @(negedge pclk);
    chk(32'({s_flag, s_pend}), 32'h0001_0021);
    apb(1, apr_pkg::A_PART, 32'h0000_0003);
    @(negedge pclk);
    chk(32'({s_flag, s_pend}), 0);
    apb(1, apr_pkg::A_ESEL0, 32'h0000_0003);
    apb(1, apr_pkg::A_ESEL1, 32'h0000_0300);
    for (int m = 0; m < 4; m++) begin
      apb(1, apr_pkg::A_PART, 32'h0000_0005);
      apb(1, apr_pkg::A_ECTRL, 32'(m) << 1);
      u_far.pulse(0, 0);
      chk(32'(e_pend), (m == 0) ? 0 : 32'h0000_0003);
    end
    apb(1, apr_pkg::A_ECTRL, 32'h0000_0052);
    u_far.pulse(1, 1);
    u_far.pulse(0, 1);
    chk(32'(e_pend), 32'h0000_0303);
    u_far.arb(1, apr_pkg::SRC_EXT, 9, 0, 0, 0);
    @(negedge pclk);
    chk(32'({e_flag, e_pend}), 32'h0001_0103);
    u_far.arb(0, 0, 0, 1, apr_pkg::SRC_EXT, 9);
    @(negedge pclk);
    chk(32'(e_pend), 32'h0000_0303);
    apb(0, 8'hFC, 0);
    chk({rdat[30:0], lerr}, 32'h0000_0001);
    tally_and_finish();
  end
endmodule : apr_request_sources_bench

// File: tb/apr_request_sources_props.sv
// concurrent checks on the request source ports
`timescale 1ns/1ps
module apr_request_sources_props (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [apr_pkg::ADDR_W-1:0]  paddr,
  input wire logic [apr_pkg::DATA_W-1:0]  pwdata,
  input wire logic                        pready,
  input wire logic [apr_pkg::DATA_W-1:0]  prdata,
  input wire logic                        start_valid,
  input wire logic [1:0]                  start_src,
  input wire logic [apr_pkg::CHIDX_W-1:0] start_chan,
  input wire logic                        cancel_valid,
  input wire logic [1:0]                  cancel_src,
  input wire logic [apr_pkg::CHIDX_W-1:0] cancel_chan,
  input wire logic [1:0]                  below_timer,
  input wire logic                        arb_lock_status,
  input wire logic                        timer_trigger,
  input wire logic [apr_pkg::CH_W-1:0]    timer_pending_mask,
  input wire logic [apr_pkg::CH_W-1:0]    ext_pending_mask,
  input wire logic [apr_pkg::CH_W-1:0]    sw_pending_mask,
  input wire logic                        timer_participation_flag,
  input wire logic                        ext_participation_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr; // completed write at its taking edge
  logic sws; // software start with no cancel in the same cycle
  assign wr = psel && penable && pready && pwrite;
  assign sws = start_valid && start_src == apr_pkg::SRC_SW && !cancel_valid;
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_one_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("no answer after one wait");
  a_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("read data outside answer");
  a_sw_copy: assert property (wr && paddr == apr_pkg::A_SWREQ
    && !start_valid && !cancel_valid
    |=> sw_pending_mask == $past(pwdata[apr_pkg::CH_W-1:0]))
    else $error("request not copied");
  a_sw_start: assert property (sws && !wr
    && !(arb_lock_status && below_timer[1])
    |=> !sw_pending_mask[$past(start_chan)])
    else $error("software bit not cleared");
  a_ext_cancel: assert property (cancel_valid
    && cancel_src == apr_pkg::SRC_EXT && !wr
    |=> ext_pending_mask[$past(cancel_chan)])
    else $error("external bit not restored");
  a_lock_block: assert property (arb_lock_status && below_timer[1]
    && sws && !wr |=> $stable(sw_pending_mask))
    else $error("start taken while locked");
  a_tmr_flag: assert property (timer_participation_flag
    == (arb_lock_status || |timer_pending_mask))
    else $error("timer flag wrong");
  a_ext_flag: assert property (ext_participation_flag == |ext_pending_mask)
    else $error("external flag wrong");
  a_trig_pulse: assert property (timer_trigger |=> !timer_trigger)
    else $error("timer trigger too long");
  c_trig: cover property (timer_trigger);
  c_blocked: cover property (arb_lock_status && sws);
  c_both: cover property (start_valid && cancel_valid);
endmodule : apr_request_sources_props

bind apr_request_sources apr_request_sources_props u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .start_valid, .start_src, .start_chan, .cancel_valid,
  .cancel_src, .cancel_chan, .below_timer, .arb_lock_status,
  .timer_trigger, .timer_pending_mask, .ext_pending_mask,
  .sw_pending_mask, .timer_participation_flag, .ext_participation_flag);
